// File: jbt_defines.svh
// constants for the boundary scan test port
`ifndef JBT_DEFINES_SVH
`define JBT_DEFINES_SVH

`define JBT_IR_W 3
`define JBT_ID_W 32
`define JBT_BSR_LEN 109
`define JBT_PIN_CELLS 108
`define JBT_CTL_CELL 108
`define JBT_Q_MAX 36

`define JBT_OP_EXTEST 3'h0
`define JBT_OP_IDCODE 3'h1
`define JBT_OP_SAMPLE_Z 3'h2
`define JBT_OP_RSV_A 3'h3
`define JBT_OP_SAMPLE 3'h4
`define JBT_OP_RSV_B 3'h5
`define JBT_OP_RSV_C 3'h6
`define JBT_OP_BYPASS 3'h7
`define JBT_IR_CAPTURE 3'h1
`define JBT_IR_RESET 3'h1

`define JBT_ID_REV 3'h0
`define JBT_ID_DEF 3'h2
`define JBT_ID_WX36 2'h3
`define JBT_ID_WX18 2'h2
`define JBT_ID_QUAD 1'h0
`define JBT_ID_BURST4 1'h1
`define JBT_ID_SEPIO 1'h0
`define JBT_ID_START 1'h1

`define JBT_BYP_RESET 1'h0
`define JBT_CTL_RESET 1'h0

`endif

// File: jbt_pkg.sv
// types shared by the boundary scan test port
package jbt_pkg;
	`include "jbt_defines.svh"

	typedef enum logic [15:0] {
		JBT_TLR = 16'h0001,
		JBT_RTI = 16'h0002,
		JBT_SEL_DR = 16'h0004,
		JBT_CAP_DR = 16'h0008,
		JBT_SH_DR = 16'h0010,
		JBT_EX1_DR = 16'h0020,
		JBT_PA_DR = 16'h0040,
		JBT_EX2_DR = 16'h0080,
		JBT_UPD_DR = 16'h0100,
		JBT_SEL_IR = 16'h0200,
		JBT_CAP_IR = 16'h0400,
		JBT_SH_IR = 16'h0800,
		JBT_EX1_IR = 16'h1000,
		JBT_PA_IR = 16'h2000,
		JBT_EX2_IR = 16'h4000,
		JBT_UPD_IR = 16'h8000
	} jbt_state_t;

	typedef struct packed {
		logic float_q;
		logic drive_q;
		logic [`JBT_Q_MAX-1:0] data;
	} jbt_q_ctl_t;
endpackage

// File: jbt_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
module jbt_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule

// File: jbt_tap_ctl_model.sv
// board test controller model driving the tap
`timescale 1ns/10ps
module jbt_tap_ctl_model (
	input wire logic tdo_i,
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o
);
	initial begin
		tck_o = 1'h0;
		tms_o = 1'h1;
		tdi_o = 1'h0;
	end
	// one tck cycle: drive while low, take tdo set by last falling edge
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		tms_o = tms;
		tdi_o = tdi;
		#1.5;
		tdo = tdo_i;
		#1.5 tck_o = 1'h1;
		#3 tck_o = 1'h0;
	endtask
	task automatic idle(input int n);
		logic t;
		repeat (n) step(1'h1, 1'h0, t);
	endtask
	// five or more tms high, then park in run-test/idle
	task automatic tap_reset();
		logic t;
		idle(6);
		step(1'h0, 1'h0, t);
	endtask
	// reserved codes are only sent when the bench asks for them
	task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
		logic t;
		step(1'h1, 1'h0, t);
		step(1'h1, 1'h0, t);
		step(1'h0, 1'h0, t);
		step(1'h0, 1'h0, t);
		for (int i = 0; i < 3; i++) step(i == 2, code[i], cap[i]);
		step(1'h1, 1'h0, t);
		step(1'h0, 1'h0, t);
		tdi_o = 1'h1; // idle tdi at its pull-up level
	endtask
	task automatic shift_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
		logic t;
		dout = '0;
		step(1'h1, 1'h0, t);
		step(1'h0, 1'h0, t);
		step(1'h0, 1'h0, t);
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'h1, 1'h0, t);
		step(1'h0, 1'h0, t);
		tdi_o = 1'h1; // idle tdi at its pull-up level
	endtask
endmodule

// File: jbt_tap_fsm.sv
// sixteen-state test access controller
`timescale 1ns/10ps
module jbt_tap_fsm
	import jbt_pkg::*;
(
	input wire logic tck_i,
	input wire logic rst_i,
	input wire logic tms_i,
	output jbt_state_t state_o
);
	jbt_state_t next_state;

	always_comb begin
		next_state = JBT_TLR;
		case (state_o)
			JBT_TLR: next_state = tms_i ? JBT_TLR : JBT_RTI;
			JBT_RTI: next_state = tms_i ? JBT_SEL_DR : JBT_RTI;
			JBT_SEL_DR: next_state = tms_i ? JBT_SEL_IR : JBT_CAP_DR;
			JBT_CAP_DR: next_state = tms_i ? JBT_EX1_DR : JBT_SH_DR;
			JBT_SH_DR: next_state = tms_i ? JBT_EX1_DR : JBT_SH_DR;
			JBT_EX1_DR: next_state = tms_i ? JBT_UPD_DR : JBT_PA_DR;
			JBT_PA_DR: next_state = tms_i ? JBT_EX2_DR : JBT_PA_DR;
			JBT_EX2_DR: next_state = tms_i ? JBT_UPD_DR : JBT_SH_DR;
			JBT_UPD_DR: next_state = tms_i ? JBT_SEL_DR : JBT_RTI;
			JBT_SEL_IR: next_state = tms_i ? JBT_TLR : JBT_CAP_IR;
			JBT_CAP_IR: next_state = tms_i ? JBT_EX1_IR : JBT_SH_IR;
			JBT_SH_IR: next_state = tms_i ? JBT_EX1_IR : JBT_SH_IR;
			JBT_EX1_IR: next_state = tms_i ? JBT_UPD_IR : JBT_PA_IR;
			JBT_PA_IR: next_state = tms_i ? JBT_EX2_IR : JBT_PA_IR;
			JBT_EX2_IR: next_state = tms_i ? JBT_UPD_IR : JBT_SH_IR;
			JBT_UPD_IR: next_state = tms_i ? JBT_SEL_DR : JBT_RTI;
			default: next_state = JBT_TLR;
		endcase
	end

	always_ff @(posedge tck_i) begin
		if (rst_i) begin
			state_o <= JBT_TLR;
		end else begin
			state_o <= next_state;
		end
	end
endmodule

// File: jbt_tap_top.sv
// boundary scan test port of a synchronous memory
`timescale 1ns/10ps
module jbt_tap_top
	import jbt_pkg::*;
#(
	parameter int Q_WIDTH = 36,
	parameter int Q_LSB = 0,
	parameter logic [10:0] MFR_CODE = 11'h2A5, // arbitrary value
	parameter logic DLL_PRESENT = 1'h1
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire logic [`JBT_PIN_CELLS-1:0] pin_state_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	output jbt_q_ctl_t q_ctl_o,
	output logic reserved_instruction_o
);
	jbt_state_t state;
	logic tap_rst;
	logic [`JBT_PIN_CELLS-1:0] pins_s;
	logic [`JBT_IR_W-1:0] ir_shift;
	logic [`JBT_IR_W-1:0] ir;
	logic [`JBT_ID_W-1:0] id_sr;
	logic [`JBT_BSR_LEN-1:0] bsr;
	logic [`JBT_PIN_CELLS-1:0] upd;
	logic ctl;
	logic byp;
	logic ext_drive;
	logic [`JBT_Q_MAX-1:0] ext_data;
	logic next_tdo;
	jbt_q_ctl_t next_q;
	jbt_q_ctl_t tck_q;
	jbt_q_ctl_t next_want;
	logic req;
	logic ack_s;
	logic rsv_tck;
	logic [1:0] ref_s;
	logic ack;

	// id word assembly
	function automatic logic [`JBT_ID_W-1:0] id_word();
		logic [16:0] cfg;
		logic [1:0] wx;
		wx = (Q_WIDTH == 18) ? `JBT_ID_WX18 : `JBT_ID_WX36;
		cfg = {2'h0, `JBT_ID_DEF, 1'h0, wx, 1'h0, DLL_PRESENT, 1'h0, `JBT_ID_QUAD,
			1'h0, `JBT_ID_BURST4, 1'h0, `JBT_ID_SEPIO, 1'h0};
		return {`JBT_ID_REV, cfg, MFR_CODE, `JBT_ID_START};
	endfunction

	// instruction that routes the boundary chain
	function automatic logic uses_bsr(input logic [`JBT_IR_W-1:0] op);
		return op == `JBT_OP_EXTEST || op == `JBT_OP_SAMPLE_Z || op == `JBT_OP_SAMPLE;
	endfunction

	// reserved codes
	function automatic logic is_reserved(input logic [`JBT_IR_W-1:0] op);
		return op == `JBT_OP_RSV_A || op == `JBT_OP_RSV_B || op == `JBT_OP_RSV_C;
	endfunction

	// output word slice of the update register
	function automatic logic [`JBT_Q_MAX-1:0] q_slice(input logic [`JBT_PIN_CELLS-1:0] v);
		logic [`JBT_Q_MAX-1:0] d;
		d = v[Q_LSB +: `JBT_Q_MAX];
		if (Q_WIDTH == 18) begin
			d[`JBT_Q_MAX-1:18] = '0;
		end
		return d;
	endfunction

	// output control plan for an instruction
	function automatic jbt_q_ctl_t plan_of(input logic [`JBT_IR_W-1:0] op, input logic drv,
		input logic [`JBT_Q_MAX-1:0] d);
		jbt_q_ctl_t p;
		p.float_q = (op == `JBT_OP_SAMPLE_Z) || (op == `JBT_OP_EXTEST && !drv);
		p.drive_q = (op == `JBT_OP_EXTEST) && drv;
		p.data = p.drive_q ? d : '0;
		return p;
	endfunction

	// power-up reset brought onto tck
	jbt_sync #(.W(1)) u_rst_sync (
		.clk_i(tck_i),
		.rst_i(1'b0),
		.d_i(rst_i),
		.q_o(tap_rst)
	);

	// pin levels synchronised before capture
	jbt_sync #(.W(`JBT_PIN_CELLS)) u_pin_sync (
		.clk_i(tck_i),
		.rst_i(tap_rst),
		.d_i(pin_state_i),
		.q_o(pins_s)
	);

	jbt_sync #(.W(1)) u_ack_sync (
		.clk_i(tck_i),
		.rst_i(tap_rst),
		.d_i(ack),
		.q_o(ack_s)
	);

	jbt_tap_fsm u_fsm (
		.tck_i(tck_i),
		.rst_i(tap_rst),
		.tms_i(tms_i),
		.state_o(state)
	);

	// instruction register
	always_ff @(posedge tck_i) begin
		if (tap_rst || state == JBT_TLR) begin
			ir_shift <= `JBT_IR_RESET;
			ir <= `JBT_IR_RESET;
		end else begin
			if (state == JBT_CAP_IR) begin
				ir_shift <= `JBT_IR_CAPTURE;
			end else if (state == JBT_SH_IR) begin
				ir_shift <= {tdi_i, ir_shift[`JBT_IR_W-1:1]};
			end
			if (state == JBT_UPD_IR) begin
				ir <= ir_shift;
			end
		end
	end

	// identification register
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			id_sr <= '0;
		end else if (ir == `JBT_OP_IDCODE) begin
			if (state == JBT_CAP_DR) begin
				id_sr <= id_word();
			end else if (state == JBT_SH_DR) begin
				id_sr <= {tdi_i, id_sr[`JBT_ID_W-1:1]};
			end
		end
	end

	// boundary chain, same length and order for both widths
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			bsr <= '0;
		end else if (uses_bsr(ir)) begin
			if (state == JBT_CAP_DR) begin
				bsr <= {ctl, pins_s};
			end else if (state == JBT_SH_DR) begin
				bsr <= {tdi_i, bsr[`JBT_BSR_LEN-1:1]};
			end
		end
	end

	// update register loaded by sample
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			upd <= '0;
		end else if (state == JBT_UPD_DR && ir == `JBT_OP_SAMPLE) begin
			upd <= bsr[`JBT_PIN_CELLS-1:0];
		end
	end

	// internal output control cell
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			ctl <= `JBT_CTL_RESET;
		end else if (state == JBT_UPD_DR && (ir == `JBT_OP_SAMPLE || ir == `JBT_OP_EXTEST)) begin
			ctl <= bsr[`JBT_CTL_CELL];
		end
	end

	// bypass bit
	always_ff @(posedge tck_i) begin
		if (tap_rst || state == JBT_TLR) begin
			byp <= `JBT_BYP_RESET;
		end else if (state == JBT_UPD_IR && ir_shift == `JBT_OP_BYPASS) begin
			byp <= `JBT_BYP_RESET;
		end else if (state == JBT_SH_DR && !uses_bsr(ir) && ir != `JBT_OP_IDCODE) begin
			byp <= tdi_i;
		end
	end

	// extest drive values taken at update-ir
	always_ff @(posedge tck_i) begin
		if (tap_rst || state == JBT_TLR) begin
			ext_drive <= 1'b0;
			ext_data <= '0;
		end else if (state == JBT_UPD_IR && ir_shift == `JBT_OP_EXTEST) begin
			ext_drive <= ctl;
			ext_data <= q_slice(upd);
		end
	end

	// plan of the active instruction, and the plan left by this edge, so tck may stop after it
	assign next_q = plan_of(ir, ext_drive, ext_data);
	always_comb begin
		next_want = next_q;
		if (state == JBT_TLR) begin
			next_want = '0;
		end else if (state == JBT_UPD_IR) begin
			next_want = plan_of(ir_shift, ctl, q_slice(upd));
		end
	end

	// handshake source: new plan only once the last one was taken
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			tck_q <= '0;
			req <= 1'b0;
		end else if (req == ack_s && next_want != tck_q) begin
			tck_q <= next_want;
			req <= ~req;
		end
	end

	always_ff @(posedge tck_i) begin
		if (tap_rst || state == JBT_TLR) begin
			rsv_tck <= 1'b0;
		end else if (state == JBT_UPD_IR) begin
			rsv_tck <= is_reserved(ir_shift);
		end
	end

	// test data out, changes on falling tck
	always_comb begin
		next_tdo = byp;
		if (state == JBT_SH_IR) begin
			next_tdo = ir_shift[0];
		end else if (ir == `JBT_OP_IDCODE) begin
			next_tdo = id_sr[0];
		end else if (uses_bsr(ir)) begin
			next_tdo = bsr[0];
		end
	end

	always_ff @(negedge tck_i) begin
		if (tap_rst) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else begin
			tdo_o <= next_tdo;
			tdo_oe_o <= (state == JBT_SH_IR) || (state == JBT_SH_DR);
		end
	end

	// reference clock side of the crossing
	jbt_sync #(.W(2)) u_ref_sync (
		.clk_i(ref_clk_i),
		.rst_i(rst_i),
		.d_i({req, rsv_tck}),
		.q_o(ref_s)
	);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			q_ctl_o <= '0;
		end else if (ref_s[1] != ack) begin
			ack <= ref_s[1];
			q_ctl_o <= tck_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reserved_instruction_o <= 1'b0;
		end else begin
			reserved_instruction_o <= ref_s[0];
		end
	end

	default clocking cb @(posedge tck_i); endclocking
	default disable iff (tap_rst);

	a_id_word_fields: assert property (state == JBT_CAP_DR && ir == `JBT_OP_IDCODE
		|=> id_sr[0] && id_sr[31:29] == `JBT_ID_REV && id_sr[26:24] == `JBT_ID_DEF
		&& id_sr[11:1] == MFR_CODE)
		else $error("id word fields wrong");
	a_id_capture: assert property (state == JBT_CAP_DR && ir == `JBT_OP_IDCODE
		|=> id_sr == id_word())
		else $error("id register not captured");
	a_id_shift_in: assert property (state == JBT_SH_DR && ir == `JBT_OP_IDCODE
		|=> id_sr[`JBT_ID_W-1] == $past(tdi_i))
		else $error("id register shift wrong");
	a_samplez_float: assert property (ir == `JBT_OP_SAMPLE_Z |-> next_q.float_q)
		else $error("sample-z left outputs driven");
	a_sample_driven: assert property (ir == `JBT_OP_SAMPLE
		|-> !next_q.float_q && !next_q.drive_q)
		else $error("sample floated outputs");
	a_extest_gate: assert property (ir == `JBT_OP_EXTEST
		|-> next_q.float_q == !ext_drive && next_q.drive_q == ext_drive)
		else $error("extest output control wrong");
	a_extest_at_upd: assert property (state == JBT_UPD_IR && ir_shift == `JBT_OP_EXTEST
		|=> ext_drive == $past(ctl) && ir == `JBT_OP_EXTEST)
		else $error("extest transfer not at update-ir");
	a_ctl_held: assert property (!(ir == `JBT_OP_SAMPLE || ir == `JBT_OP_EXTEST)
		|=> $stable(ctl))
		else $error("control cell changed outside sample/extest");
	a_chain_tdi: assert property (state == JBT_SH_DR && uses_bsr(ir)
		|=> bsr[`JBT_BSR_LEN-1] == $past(tdi_i) && bsr[0] == $past(bsr[1]))
		else $error("chain shift wrong");
	a_bypass_clear: assert property (state == JBT_UPD_IR && ir_shift == `JBT_OP_BYPASS
		|=> byp == 1'b0)
		else $error("bypass not cleared");
	a_bypass_last: assert property ((state == JBT_SH_DR && ir == `JBT_OP_BYPASS) ##1
		(state != JBT_SH_DR) |-> byp == $past(tdi_i))
		else $error("bypass lost last bit");
	a_tms_reset: assert property (tms_i [*5] |=> state == JBT_TLR)
		else $error("five tms highs did not reset");

	c_extest_load: cover property (state == JBT_UPD_IR && ir_shift == `JBT_OP_EXTEST && ctl);
	c_id_shift: cover property (state == JBT_SH_DR && ir == `JBT_OP_IDCODE);
	c_sample_upd: cover property (state == JBT_UPD_DR && ir == `JBT_OP_SAMPLE);
	c_bypass_shift: cover property (state == JBT_SH_DR && ir == `JBT_OP_BYPASS);
endmodule

// File: jbt_tap_top_test.sv
// self-checking bench for the boundary scan test port
`timescale 1ns/10ps
module jbt_tap_top_test;
	import jbt_pkg::*;
	localparam logic [10:0] MFR = 11'h15B; // arbitrary value
	localparam logic [31:0] ID_EXP = {3'h0, 17'h02688, MFR, 1'h1};
	localparam logic [35:0] QDAT = 36'h9A5C3E17B;
	logic ref_clk, rst, tck, tms, tdi, tdo, tdo_oe, rsv;
	logic [107:0] pins;
	logic [127:0] dout;
	logic [2:0] cap;
	jbt_q_ctl_t q_ctl;
	int failures, n_tests;

	jbt_tap_top #(.MFR_CODE(MFR)) u_jbt_tap_top (
		.ref_clk_i(ref_clk), .rst_i(rst), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.pin_state_i(pins), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .q_ctl_o(q_ctl),
		.reserved_instruction_o(rsv));
	jbt_tap_ctl_model u_jbt_tap_ctl_model (.tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

	initial begin
		ref_clk = 1'h0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// wait bounded for the output plan to cross, then compare it
	task automatic chk_q(input logic f, input logic d);
		int i;
		for (i = 0; i < 20 && q_ctl[37:36] !== {f, d}; i++) @(negedge ref_clk);
		chk(128'(q_ctl[37:36]), 128'({f, d}));
		if (d) chk(128'(q_ctl.data), 128'(QDAT));
	endtask
	task automatic chk_rsv(input logic exp);
		int i;
		for (i = 0; i < 20 && rsv !== exp; i++) @(negedge ref_clk);
		chk(128'(rsv), 128'(exp));
	endtask
	task automatic end_sim();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic t_idcode();
		int n_oe = 0;
		fork
			u_jbt_tap_ctl_model.shift_dr(32, 128'h0, dout);
			forever @(posedge tck) n_oe += int'(tdo_oe === 1'h1);
		join_any
		disable fork;
		chk(128'(dout[31:0]), 128'(ID_EXP));
		chk(128'(n_oe), 128'h20);
	endtask
	task automatic t_bypass();
		u_jbt_tap_ctl_model.load_ir(3'h7, cap);
		chk(128'(cap), 128'h1);
		u_jbt_tap_ctl_model.shift_dr(4, 128'hD, dout);
		chk(128'(dout[3:0]), 128'hA);
		u_jbt_tap_ctl_model.shift_dr(1, 128'h0, dout);
		chk(128'(dout[0]), 128'h1);
	endtask
	task automatic t_chain();
		u_jbt_tap_ctl_model.load_ir(3'h4, cap);
		chk_q(1'h0, 1'h0);
		u_jbt_tap_ctl_model.shift_dr(109, {19'h0, 1'h1, 72'h0, QDAT}, dout);
		chk(dout, {19'h0, 1'h0, pins});
		chk_q(1'h0, 1'h0);
		u_jbt_tap_ctl_model.load_ir(3'h0, cap);
		chk_q(1'h0, 1'h1);
		u_jbt_tap_ctl_model.shift_dr(109, 128'h0, dout);
		chk(128'(dout[108]), 128'h1);
		chk_q(1'h0, 1'h1);
		u_jbt_tap_ctl_model.load_ir(3'h2, cap);
		chk_q(1'h1, 1'h0);
		u_jbt_tap_ctl_model.shift_dr(109, {19'h0, 1'h1, 108'h0}, dout);
		chk(128'(dout[107:0]), 128'(pins));
		u_jbt_tap_ctl_model.load_ir(3'h0, cap);
		chk_q(1'h1, 1'h0);
	endtask
	task automatic t_reserved();
		logic [2:0] codes[3] = '{3'h3, 3'h5, 3'h6};
		foreach (codes[i]) begin
			u_jbt_tap_ctl_model.load_ir(codes[i], cap);
			chk_rsv(1'h1);
		end
		u_jbt_tap_ctl_model.load_ir(3'h7, cap);
		chk_rsv(1'h0);
	endtask

	initial begin
		#100000;
		failures++;
		end_sim();
	end

	initial begin
		rst = 1'h1;
		pins = 108'hC3A59F01E7D24B681A5CF0E396B;
		failures = 0;
		n_tests = 0;
		fork
			begin
				repeat (3) @(negedge ref_clk);
				rst = 1'h0;
			end
			u_jbt_tap_ctl_model.idle(30);
		join
		u_jbt_tap_ctl_model.tap_reset();
		t_idcode();
		t_bypass();
		t_chain();
		t_reserved();
		end_sim();
	end
endmodule
